// >>> tcsmc_timer.sv
/*
  Timer with selectable count source and per-channel match actions,
  reached over AXI4-Lite, with sticky match interrupts and a mask.
  Assumes aclk is the peripheral clock and the capture pin is already
  synchronous to it.
*/
module tcsmc_timer #(
  parameter int NUM_CH = 10
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic [tcsmc_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [tcsmc_pkg::DATA_W-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [tcsmc_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [tcsmc_pkg::DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic capture_input_zero,
  output logic irq
);

  localparam int TC_W = tcsmc_pkg::TC_W;
  localparam int PC_W = tcsmc_pkg::PC_W;
  localparam int MA_W = NUM_CH * tcsmc_pkg::MA_BITS;
  localparam int MV_W = NUM_CH * TC_W;
  localparam logic [7:0] MV_END = 8'(tcsmc_pkg::OFF_MATCH_VAL + 4 * NUM_CH);

  typedef struct packed {
    logic counter_enable_bit;
    logic crst;
    logic [TC_W-1:0] timer_counter;
    logic [PC_W-1:0] pre;
    logic [PC_W-1:0] prescale_counter;
    logic [tcsmc_pkg::CNT_SRC_W-1:0] count_source_control;
    logic [MA_W-1:0] match_action_control;
    logic [MV_W-1:0] match_value;
    logic [NUM_CH-1:0] eq_prev;
    logic [NUM_CH-1:0] irq_status;
    logic [NUM_CH-1:0] irq_mask;
    logic aw_have;
    logic [7:0] aw_addr;
    logic w_have;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic irq;
  } tcsmc_state_t;

  tcsmc_state_t state_reg;
  tcsmc_state_t state_next;
  tcsmc_pkg::tcsmc_event_t edge_event;
  logic [NUM_CH-1:0] eq;
  logic [NUM_CH-1:0] new_match;
  logic [NUM_CH-1:0] ie_bits;
  logic [NUM_CH-1:0] rst_bits;
  logic [NUM_CH-1:0] stop_bits;
  logic [1:0] count_mode_field;
  logic count_ok;
  logic tick;
  logic stop_hit;
  logic rst_hit;

  // Aligned word address with the byte lane bits dropped
  function automatic logic [7:0] word_addr(input logic [7:0] a);
    return {a[7:2], 2'b00};
  endfunction

  // Decode of the match value window, shared by reads and writes
  function automatic logic is_match_val(input logic [7:0] a);
    return word_addr(a) >= tcsmc_pkg::OFF_MATCH_VAL && word_addr(a) < MV_END;
  endfunction

  // Known register word or match value; anything else answers with an error
  function automatic logic is_mapped(input logic [7:0] a);
    logic hit;
    hit = is_match_val(a);
    case (word_addr(a))
      tcsmc_pkg::OFF_TMR_CTRL,
      tcsmc_pkg::OFF_TC,
      tcsmc_pkg::OFF_PRE,
      tcsmc_pkg::OFF_PC,
      tcsmc_pkg::OFF_CNT_SRC,
      tcsmc_pkg::OFF_MATCH_CTRL,
      tcsmc_pkg::OFF_IRQ_STATUS,
      tcsmc_pkg::OFF_IRQ_MASK: hit = 1'b1;
      default: hit = hit;
    endcase
    return hit;
  endfunction

  // Channel number of an address inside the match value window
  // Outside the window the index is meaningless; every user guards with is_match_val
  function automatic int mv_index(input logic [7:0] a);
    logic [7:0] off;
    off = word_addr(a) - tcsmc_pkg::OFF_MATCH_VAL;
    return int'(off[7:2]);
  endfunction

  // Byte-lane merge of write data over an old word
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] data,
                                        input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[8*b +: 8] = data[8*b +: 8];
      end
    end
    return res;
  endfunction

  // Sampler runs in every mode, so a switch to counter mode sees settled samples
  tcsmc_edge_detect u_edge (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(ce),
    .capture_input_zero(capture_input_zero),
    .count_input_select(state_reg.count_source_control[tcsmc_pkg::CIS_LSB +: 2]),
    .edge_event(edge_event)
  );

  // Per-channel compare and action bit split
  genvar k;
  generate
    for (k = 0; k < NUM_CH; k++) begin : g_ch
      assign eq[k] = state_reg.timer_counter == state_reg.match_value[k*TC_W +: TC_W];
      assign ie_bits[k] = state_reg.match_action_control[k*3 + tcsmc_pkg::MA_IE];
      assign rst_bits[k] = state_reg.match_action_control[k*3 + tcsmc_pkg::MA_RST];
      assign stop_bits[k] = state_reg.match_action_control[k*3 + tcsmc_pkg::MA_STOP];
    end
  endgenerate

  // A match counts once, in the cycle the counter first equals the value
  assign new_match = eq & ~state_reg.eq_prev & {NUM_CH{state_reg.counter_enable_bit}};
  assign stop_hit = |(new_match & stop_bits);
  assign rst_hit = |(eq & rst_bits) & state_reg.counter_enable_bit;

  // Count source qualification
  assign count_mode_field = state_reg.count_source_control[tcsmc_pkg::CTM_LSB +: 2];
  always_comb begin
    case (count_mode_field)
      tcsmc_pkg::CTM_TIMER: count_ok = 1'b1;
      tcsmc_pkg::CTM_RISE: count_ok = edge_event == tcsmc_pkg::TCSMC_EV_RISE;
      tcsmc_pkg::CTM_FALL: count_ok = edge_event == tcsmc_pkg::TCSMC_EV_FALL;
      default: count_ok = edge_event != tcsmc_pkg::TCSMC_EV_NONE;
    endcase
  end

  // Stop wins over the tick so the timer counter holds at the match value and the prescale counter keeps its count
  assign tick = state_reg.counter_enable_bit & count_ok & ~stop_hit;

  // Handshake readies; nothing is taken while the clock enable is low
  assign s_axi_awready = ce & ~state_reg.aw_have & ~state_reg.bvalid;
  assign s_axi_wready = ce & ~state_reg.w_have & ~state_reg.bvalid;
  assign s_axi_arready = ce & ~state_reg.rvalid;
  assign s_axi_bvalid = state_reg.bvalid;
  assign s_axi_bresp = state_reg.bresp;
  assign s_axi_rvalid = state_reg.rvalid;
  assign s_axi_rdata = state_reg.rdata;
  assign s_axi_rresp = state_reg.rresp;
  assign irq = state_reg.irq;

  // Counting, match actions and register access in one next-state block
  always_comb begin
    logic [31:0] wr_word;
    logic [31:0] rd_word;
    logic [31:0] old_word;
    logic [NUM_CH-1:0] clr;
    logic [7:0] wa;
    int wi;
    int ri;
    // Every temporary starts at a known value so no path infers a latch
    wr_word = '0;
    rd_word = '0;
    old_word = '0;
    clr = '0;
    wa = state_reg.aw_addr;
    wi = mv_index(state_reg.aw_addr);
    ri = mv_index(s_axi_araddr);
    state_next = state_reg;
    if (ce) begin
      state_next.eq_prev = eq;

      // Prescaler and timer counter
      // Counter reset beats counting and clears itself one clock later
      if (state_reg.crst) begin
        state_next.timer_counter = tcsmc_pkg::RST_TC;
        state_next.prescale_counter = tcsmc_pkg::RST_PC;
        state_next.crst = 1'b0;
      end else if (tick) begin
        if (state_reg.prescale_counter == state_reg.pre) begin
          state_next.prescale_counter = tcsmc_pkg::RST_PC;
          if (rst_hit) begin
            state_next.timer_counter = tcsmc_pkg::RST_TC;
          end else begin
            state_next.timer_counter = state_reg.timer_counter + 16'h0001;
          end
        end else begin
          state_next.prescale_counter = state_reg.prescale_counter + 8'h01;
        end
      end

      // Stop takes effect at the edge after the counter reached the value
      if (stop_hit) begin
        state_next.counter_enable_bit = 1'b0;
      end

      // Accept write address and data in either order
      if (s_axi_awvalid && s_axi_awready) begin
        state_next.aw_have = 1'b1;
        state_next.aw_addr = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        state_next.w_have = 1'b1;
        state_next.w_data = s_axi_wdata;
        state_next.w_strb = s_axi_wstrb;
      end

      // Commit once both halves are held; software beats hardware here
      if (state_reg.aw_have && state_reg.w_have) begin
        state_next.aw_have = 1'b0;
        state_next.w_have = 1'b0;
        state_next.bvalid = 1'b1;
        state_next.bresp = is_mapped(wa) ? tcsmc_pkg::RESP_OKAY : tcsmc_pkg::RESP_SLVERR;
        // Merge base is the current contents, so unwritten byte lanes keep their value
        case (word_addr(wa))
          tcsmc_pkg::OFF_TMR_CTRL: old_word = 32'({state_reg.crst, state_reg.counter_enable_bit});
          tcsmc_pkg::OFF_TC: old_word = 32'(state_reg.timer_counter);
          tcsmc_pkg::OFF_PRE: old_word = 32'(state_reg.pre);
          tcsmc_pkg::OFF_PC: old_word = 32'(state_reg.prescale_counter);
          tcsmc_pkg::OFF_CNT_SRC: old_word = 32'(state_reg.count_source_control);
          tcsmc_pkg::OFF_MATCH_CTRL: old_word = 32'(state_reg.match_action_control);
          tcsmc_pkg::OFF_IRQ_MASK: old_word = 32'(state_reg.irq_mask);
          default: old_word = '0;
        endcase
        if (is_match_val(wa)) begin
          old_word = 32'(state_reg.match_value[wi*TC_W +: TC_W]);
        end
        wr_word = merge(old_word, state_reg.w_data, state_reg.w_strb);
        // Only each register's own width is kept; upper bits read back as zero
        case (word_addr(wa))
          tcsmc_pkg::OFF_TMR_CTRL: begin
            state_next.counter_enable_bit = wr_word[tcsmc_pkg::CEN_BIT];
            state_next.crst = wr_word[tcsmc_pkg::CRST_BIT];
          end
          tcsmc_pkg::OFF_TC: state_next.timer_counter = wr_word[TC_W-1:0];
          tcsmc_pkg::OFF_PRE: state_next.pre = wr_word[PC_W-1:0];
          tcsmc_pkg::OFF_PC: state_next.prescale_counter = wr_word[PC_W-1:0];
          tcsmc_pkg::OFF_CNT_SRC: begin
            state_next.count_source_control = wr_word[tcsmc_pkg::CNT_SRC_W-1:0];
          end
          tcsmc_pkg::OFF_MATCH_CTRL: begin
            state_next.match_action_control = wr_word[MA_W-1:0];
          end
          tcsmc_pkg::OFF_IRQ_STATUS: clr = wr_word[NUM_CH-1:0];
          tcsmc_pkg::OFF_IRQ_MASK: state_next.irq_mask = wr_word[NUM_CH-1:0];
          default: clr = '0;
        endcase
        if (is_match_val(wa)) begin
          state_next.match_value[wi*TC_W +: TC_W] = wr_word[TC_W-1:0];
        end
      end
      // Write answer stands until the master takes it
      if (state_reg.bvalid && s_axi_bready) begin
        state_next.bvalid = 1'b0;
      end

      // Sticky match flags: a new match beats a clear in the same cycle
      state_next.irq_status = (state_reg.irq_status & ~clr) | (new_match & ie_bits);

      // Read data are captured at the address handshake
      case (word_addr(s_axi_araddr))
        tcsmc_pkg::OFF_TMR_CTRL: rd_word = 32'({state_reg.crst, state_reg.counter_enable_bit});
        tcsmc_pkg::OFF_TC: rd_word = 32'(state_reg.timer_counter);
        tcsmc_pkg::OFF_PRE: rd_word = 32'(state_reg.pre);
        tcsmc_pkg::OFF_PC: rd_word = 32'(state_reg.prescale_counter);
        tcsmc_pkg::OFF_CNT_SRC: rd_word = 32'(state_reg.count_source_control);
        tcsmc_pkg::OFF_MATCH_CTRL: rd_word = 32'(state_reg.match_action_control);
        tcsmc_pkg::OFF_IRQ_STATUS: rd_word = 32'(state_reg.irq_status);
        tcsmc_pkg::OFF_IRQ_MASK: rd_word = 32'(state_reg.irq_mask);
        default: rd_word = '0;
      endcase
      if (is_match_val(s_axi_araddr)) begin
        rd_word = 32'(state_reg.match_value[ri*TC_W +: TC_W]);
      end
      // No new read is taken while the answer stands, so rdata holds steady
      if (s_axi_arvalid && s_axi_arready) begin
        state_next.rvalid = 1'b1;
        state_next.rdata = rd_word;
        state_next.rresp = is_mapped(s_axi_araddr) ? tcsmc_pkg::RESP_OKAY : tcsmc_pkg::RESP_SLVERR;
      end else if (state_reg.rvalid && s_axi_rready) begin
        state_next.rvalid = 1'b0;
      end

      // Level interrupt follows the flags and mask in the same edge
      state_next.irq = |(state_next.irq_status & state_next.irq_mask);
    end
  end

  // Every control field clears on reset: timer mode, no match action
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

endmodule // tcsmc_timer

// >>> tcsmc_pkg.sv
/*
  Shared constants for the timer count-source and match-action block:
  register byte offsets, field positions, reset values, mode codes and
  the capture-event type. Assumes a 32-bit AXI4-Lite register port.
*/
package tcsmc_pkg;

  // Bus and counter widths
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int TC_W = 16;
  localparam int PC_W = 8;

  // Register byte offsets
  localparam logic [7:0] OFF_TMR_CTRL = 8'h00;
  localparam logic [7:0] OFF_TC = 8'h04;
  localparam logic [7:0] OFF_PRE = 8'h08;
  localparam logic [7:0] OFF_PC = 8'h0C;
  localparam logic [7:0] OFF_CNT_SRC = 8'h10;
  localparam logic [7:0] OFF_MATCH_CTRL = 8'h14;
  localparam logic [7:0] OFF_IRQ_STATUS = 8'h20;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h24;
  localparam logic [7:0] OFF_MATCH_VAL = 8'h40;

  // Timer control fields
  localparam int CEN_BIT = 0;
  localparam int CRST_BIT = 1;

  // Count source control fields
  localparam int CTM_LSB = 0;
  localparam int CIS_LSB = 2;
  localparam int CNT_SRC_W = 4;

  // Match action field positions inside one channel's group
  localparam int MA_IE = 0;
  localparam int MA_RST = 1;
  localparam int MA_STOP = 2;
  localparam int MA_BITS = 3;

  // Reset values
  localparam logic [CNT_SRC_W-1:0] RST_CNT_SRC = 4'h0;
  localparam logic [TC_W-1:0] RST_TC = 16'h0000;
  localparam logic [PC_W-1:0] RST_PC = 8'h00;
  localparam logic [PC_W-1:0] RST_PRE = 8'h00;

  // Count mode and input select codes
  localparam logic [1:0] CTM_TIMER = 2'h0;
  localparam logic [1:0] CTM_RISE = 2'h1;
  localparam logic [1:0] CTM_FALL = 2'h2;
  localparam logic [1:0] CTM_BOTH = 2'h3;
  localparam logic [1:0] CIS_CAPTURE_PIN_ZERO = 2'h0;

  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Classified change between two consecutive capture samples
  typedef enum logic [1:0] {
    TCSMC_EV_NONE,
    TCSMC_EV_RISE,
    TCSMC_EV_FALL
  } tcsmc_event_t;

endpackage

// >>> tcsmc_edge_detect.sv
/*
  Capture input sampler and edge classifier.
  Assumes the capture pin is already synchronous to aclk.
*/
module tcsmc_edge_detect (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic capture_input_zero,
  input wire logic [1:0] count_input_select,
  output tcsmc_pkg::tcsmc_event_t edge_event
);

  typedef struct packed {
    logic sample;
    logic prev;
    logic primed;
    logic loaded;
  } tcsmc_edge_state_t;

  tcsmc_edge_state_t state_reg;
  tcsmc_edge_state_t state_next;
  logic sel_pin;

  // Reserved selections see a constant low, so they never raise an edge
  assign sel_pin = (count_input_select == tcsmc_pkg::CIS_CAPTURE_PIN_ZERO) ? capture_input_zero : 1'b0;

  // Take one sample per clock and keep the previous one
  always_comb begin
    state_next = state_reg;
    if (ce) begin
      state_next.sample = sel_pin;
      state_next.prev = state_reg.sample;
      state_next.loaded = 1'b1;
      state_next.primed = state_reg.loaded; // Prev holds a real sample from here on
    end
  end

  // Primed avoids a false edge from the reset value of the sample
  always_comb begin
    edge_event = tcsmc_pkg::TCSMC_EV_NONE;
    if (state_reg.primed && state_reg.sample != state_reg.prev) begin
      edge_event = state_reg.sample ? tcsmc_pkg::TCSMC_EV_RISE : tcsmc_pkg::TCSMC_EV_FALL;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

endmodule // tcsmc_edge_detect

// >>> tcsmc_timer_properties.sv
/*
  Concurrent checks on the timer register port and interrupt line.
  Sees only the tcsmc_timer ports; bound to every instance below.
*/
module tcsmc_timer_chk #(
  parameter int NUM_CH = 10
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic irq
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  // Whole write or read accepted at this edge
  sequence wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && ce;
  endsequence
  sequence rd_taken;
    s_axi_arvalid && s_axi_arready && ce;
  endsequence
  // Write answer comes after one quiet edge
  sequence wr_answer;
    !s_axi_bvalid ##1 s_axi_bvalid;
  endsequence

  write_latency_a: assert property (wr_taken |=> wr_answer)
    else $error("write answer not two edges after handshake");
  read_latency_a: assert property (rd_taken |=> s_axi_rvalid)
    else $error("read answer late");
  bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer dropped early");
  rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
    else $error("read answer dropped early");
  // Second write must wait until the answer is taken
  wr_blocked_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write accepted during answer");
  reset_quiet_a: assert property ($rose(aresetn) |-> !s_axi_bvalid && !s_axi_rvalid && !irq)
    else $error("outputs busy out of reset");
  wr_unmapped_a: assert property ((wr_taken ##0 s_axi_awaddr == 8'h30) |=>
    ##1 s_axi_bresp == tcsmc_pkg::RESP_SLVERR)
    else $error("unmapped write not refused");
  match_rsvd_a: assert property ((rd_taken ##0 s_axi_araddr == 8'h14) |=>
    (s_axi_rdata >> (3 * NUM_CH)) == 32'h0)
    else $error("unused match control bits set");
  src_rsvd_a: assert property ((rd_taken ##0 s_axi_araddr == 8'h10) |=>
    s_axi_rdata[31:4] == 28'h0)
    else $error("unused count source bits set");
  // Irq falls in the same edge as the mask update; the check allows two edges beyond it
  mask_off_a: assert property ((wr_taken ##0 s_axi_awaddr == 8'h24 &&
    s_axi_wdata == 32'h0) |=> ##3 !irq)
    else $error("irq high with all masked");
endmodule // tcsmc_timer_chk

bind tcsmc_timer tcsmc_timer_chk #(.NUM_CH(NUM_CH)) tcsmc_timer_chk_i (
  .aclk(aclk), .aresetn(aresetn), .ce(ce), .s_axi_awaddr(s_axi_awaddr),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wdata(s_axi_wdata), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .irq(irq));

// >>> tcsmc_pulse_src.sv
/*
  Pulse source for the capture pin: a burst of whole pulses on request.
  Assumes the requester waits for busy to fall before asking again.
*/
module tcsmc_pulse_src (
  input wire logic aclk,
  input wire logic start,
  input wire logic [7:0] pulses,
  input wire logic [3:0] half,
  output logic pin,
  output logic busy
);
  timeunit 1ns;
  timeprecision 1ps;
  // Levels last two clocks or more, else the sampler could miss an edge
  initial begin
    pin = 1'b0;
    busy = 1'b0;
    forever begin
      @(posedge aclk);
      if (start) begin
        busy <= 1'b1;
        repeat (2 * pulses) begin
          repeat ((half < 4'h2) ? 4'h2 : half) @(posedge aclk);
          pin <= ~pin;
        end
        busy <= 1'b0;
      end
    end
  end
endmodule // tcsmc_pulse_src

// >>> tcsmc_timer_tb.sv
/*
  Self-checking bench for tcsmc_timer: registers, count sources, match
  actions and interrupt. Assumes the pulse model and the bound checker.
*/
module tcsmc_timer_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, awready, wready;
  logic bvalid, arready, rvalid, irq, cap, go, busy, ce;
  logic [1:0] bresp, rresp, r;
  logic [7:0] awaddr, araddr, np, n;
  logic [3:0] hf;
  logic [31:0] wdata, rdata, d, m, p, seed;
  int miscompares, n_checks, cyc;
  logic [7:0] offs[8] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h20, 8'h24};
  logic [3:0] mds[4] = '{4'h1, 4'h2, 4'h3, 4'h5};
  int mul[4] = '{1, 1, 2, 0};

  tcsmc_timer #(.NUM_CH(10)) tcsmc_timer_i (
    .aclk(aclk), .aresetn(aresetn), .ce(ce), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .capture_input_zero(cap), .irq(irq));
  tcsmc_pulse_src tcsmc_pulse_src_i (
    .aclk(aclk), .start(go), .pulses(np), .half(hf), .pin(cap), .busy(busy));

  // 100 MHz clock
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  task automatic end_sim();
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // Cut a hang short
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      miscompares = miscompares + 1;
      end_sim();
    end
  end

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    n_checks++;
    if (s !== e) begin
      $display("unexpected %s: expected %h seen %h", nm, e, s);
      miscompares++;
    end
  endtask

  // Write; each half is released at the edge that takes it
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    logic pa, pw, ta, tw;
    @(posedge aclk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    pa = 1'b1;
    pw = 1'b1;
    while (pa || pw) begin
      @(negedge aclk);
      ta = pa && awready;
      tw = pw && wready;
      @(posedge aclk);
      if (ta) begin
        awvalid <= 1'b0;
        pa = 1'b0;
      end
      if (tw) begin
        wvalid <= 1'b0;
        pw = 1'b0;
      end
    end
    do @(negedge aclk); while (bvalid !== 1'b1);
    r = bresp;
    @(posedge aclk);
    bready <= 1'b1;
    @(posedge aclk);
    bready <= 1'b0;
  endtask

  // Read; ready comes late on purpose so the answer must stand
  task automatic rd(input logic [7:0] a);
    logic t;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    t = 1'b0;
    while (!t) begin
      @(negedge aclk);
      t = arready;
      @(posedge aclk);
    end
    arvalid <= 1'b0;
    do @(negedge aclk); while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    @(posedge aclk);
    rready <= 1'b1;
    @(posedge aclk);
    rready <= 1'b0;
  endtask

  task automatic w(input logic [7:0] a, input logic [31:0] v);
    wr(a, v);
    chk("bresp", 32'h0, {30'h0, r});
  endtask

  task automatic rc(input logic [7:0] a, input logic [31:0] e, input string nm);
    rd(a);
    chk(nm, e, d);
  endtask

  task automatic irqc(input logic e);
    repeat (3) @(negedge aclk);
    chk("irq", {31'h0, e}, {31'h0, irq});
  endtask

  task automatic wait_irq();
    for (int k = 0; k < 4000 && irq !== 1'b1; k++) @(negedge aclk);
    chk("irq_raised", 32'h1, {31'h0, irq});
  endtask

  task automatic pulse(input logic [7:0] cnt, input logic [3:0] h);
    @(posedge aclk);
    np <= cnt;
    hf <= h;
    go <= 1'b1;
    @(posedge aclk);
    go <= 1'b0;
    @(negedge aclk);
    while (busy) @(negedge aclk);
  endtask

  initial begin
    aresetn = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready, go} = 6'h0;
    ce = 1'b1;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0;
    np = 8'h00;
    hf = 4'h2;
    seed = 32'hF2F5;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    foreach (offs[i]) rc(offs[i], 32'h0, "reset_value");
    // Fields beyond the top channel and above the count source field read zero
    w(8'h14, 32'hFFFFFFFF);
    rc(8'h14, 32'h3FFFFFFF, "match_ctrl");
    w(8'h10, 32'hFFFFFFFF);
    rc(8'h10, 32'h0000000F, "count_src");
    w(8'h10, 32'h0);
    // Timer mode: channel 0 stops and interrupts at a random value
    m = 32'h1 + rnd() % 32'h20;
    p = rnd() % 32'h4;
    w(8'h24, 32'h3FF);
    w(8'h40, m);
    w(8'h08, p);
    w(8'h14, 32'h5);
    w(8'h00, 32'h2);
    w(8'h00, 32'h1);
    wait_irq();
    rc(8'h04, m, "tc_stop");
    rc(8'h0C, 32'h0, "pc_stop");
    rc(8'h00, 32'h0, "enable_cleared");
    rc(8'h20, 32'h1, "status");
    w(8'h20, 32'h1);
    irqc(1'b0);
    // Counter modes and a reserved select; capture control sits elsewhere
    w(8'h14, 32'h0);
    w(8'h08, 32'h0);
    for (int i = 0; i < 4; i++) begin
      n = 8'h1 + 8'(rnd() % 32'h14);
      w(8'h00, 32'h2);
      w(8'h10, {28'h0, mds[i]});
      w(8'h00, 32'h1);
      pulse(n, 4'h2 + 4'(rnd() % 32'h3));
      repeat (4) @(posedge aclk);
      w(8'h00, 32'h0);
      rc(8'h04, 32'(n) * mul[i], "tc_count");
    end
    // Clock enable low freezes the counter and the capture sampler
    w(8'h10, 32'h3);
    w(8'h00, 32'h2);
    w(8'h00, 32'h1);
    ce <= 1'b0;
    pulse(8'h3, 4'h2);
    @(posedge aclk);
    ce <= 1'b1;
    w(8'h00, 32'h0);
    rc(8'h04, 32'h0, "tc_frozen");
    // Channel 1 resets the count and interrupts; mask and clear
    w(8'h10, 32'h0);
    m = 32'h3 + rnd() % 32'h8;
    w(8'h44, m);
    w(8'h14, 32'h18);
    w(8'h00, 32'h2);
    w(8'h00, 32'h1);
    wait_irq();
    repeat (40) @(posedge aclk);
    w(8'h00, 32'h0);
    rd(8'h04);
    chk("tc_bound", 32'h1, {31'h0, d <= m});
    rc(8'h20, 32'h2, "status");
    w(8'h24, 32'h0);
    irqc(1'b0);
    w(8'h24, 32'h2);
    irqc(1'b1);
    w(8'h20, 32'h2);
    irqc(1'b0);
    // Wrap past the top value raises nothing
    w(8'h14, 32'h0);
    w(8'h04, 32'hFFFE);
    w(8'h00, 32'h1);
    repeat (20) @(posedge aclk);
    w(8'h00, 32'h0);
    rd(8'h04);
    chk("tc_wrap", 32'h1, {31'h0, d < 32'h40});
    rc(8'h20, 32'h0, "status");
    irqc(1'b0);
    // Unmapped place is refused both ways
    wr(8'h30, 32'hA5);
    chk("bresp_unmapped", 32'h2, {30'h0, r});
    rd(8'h30);
    chk("rresp_unmapped", 32'h2, {30'h0, r});
    chk("rdata_unmapped", 32'h0, d);
    // Second reset in mid-run
    w(8'h10, 32'h3);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rc(8'h10, 32'h0, "count_src_reset");
    end_sim();
  end
endmodule // tcsmc_timer_tb
